// ### hw/lrc_pkg.sv
package lrc_pkg;
    // channel count: index 0 is the low-range channel 4, 1..3 are 5..7
    localparam int LRC_NCH = 4;
    // voltage code width
    localparam int LRC_VW = 6;
    // width of a target expressed in microvolts
    localparam int LRC_UVW = 22;
    // avalon byte address width
    localparam int LRC_AW = 10;
    // avalon data width
    localparam int LRC_DW = 32;
    // register indices; the byte address is four times the index
    localparam logic [3:0][7:0] LRC_VSEL_IDX = {8'h5E, 8'h5C, 8'h5A, 8'h58};
    localparam logic [3:0][7:0] LRC_CTRL_IDX = {8'h5F, 8'h5D, 8'h5B, 8'h59};
    // control register field positions
    localparam int LRC_CLAMP_BIT = 7;
    localparam int LRC_ALPM_BIT = 6;
    localparam int LRC_COMP_MSB = 5;
    localparam int LRC_COMP_LSB = 4;
    localparam int LRC_POK_BIT = 3;
    localparam int LRC_RSVD_BIT = 2;
    localparam int LRC_ADE_BIT = 1;
    localparam int LRC_SS_BIT = 0;
    // voltage register field position
    localparam int LRC_VCODE_MSB = 5;
    // reset values held until the factory defaults are loaded
    localparam logic [5:0] LRC_VCODE_RST = 6'h00;
    localparam logic [1:0] LRC_COMP_RST = 2'h0;
    localparam logic LRC_BIT_RST = 1'b0;
    localparam logic LRC_WAIT_RST = 1'b1;
    // compensation code for a capacitor placed at the regulator pins
    localparam logic [1:0] LRC_COMP_FAST = 2'h0;
    // transfer curves in microvolts
    localparam logic [21:0] LRC_LO_BASE_UV = 22'h061A80;
    localparam logic [21:0] LRC_LO_STEP_UV = 22'h0030D4;
    localparam logic [21:0] LRC_HI_BASE_UV = 22'h0C3500;
    localparam logic [21:0] LRC_HI_STEP_UV = 22'h00C350;
    // clock rate and ramp rates
    localparam int LRC_CLK_MHZ = 10;
    localparam int LRC_FAST_MV_PER_US = 100;
    localparam int LRC_SLOW_MV_PER_US = 5;
    // microvolts moved per clock cycle at each rate
    localparam logic [21:0] LRC_FAST_STEP_UV =
        22'(LRC_FAST_MV_PER_US * 1000 / LRC_CLK_MHZ);
    localparam logic [21:0] LRC_SLOW_STEP_UV =
        22'(LRC_SLOW_MV_PER_US * 1000 / LRC_CLK_MHZ);
endpackage

// ### hw/lrc_chan.sv
`timescale 1ns/10ps
// one regulator channel: ramps the target and drives the discharge switch
module lrc_chan #(
    parameter bit LOW_RANGE = 1'b0 // selects the channel-4 transfer curve
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [lrc_pkg::LRC_VW-1:0] vcode_i,
    input wire logic ramp_slow_i,
    input wire logic discharge_en_i,
    input wire logic reg_enable_i,
    output logic [lrc_pkg::LRC_UVW-1:0] target_uv_o,
    output logic ramp_busy_o,
    output logic discharge_on_o
);
    import lrc_pkg::*;

    // whole channel state
    typedef struct packed {
        logic [LRC_UVW-1:0] cur; // ramped target
        logic busy; // target not yet at goal
        logic dis; // discharge resistor connected
    } lrc_chan_st_t;

    lrc_chan_st_t st_r;
    lrc_chan_st_t st_nxt;
    logic [LRC_UVW-1:0] goal; // where the ramp heads
    logic [LRC_UVW-1:0] step; // largest move per cycle
    logic [LRC_UVW-1:0] gap; // distance left to goal

    // next state: goal, ramp step and discharge switch
    always_comb begin
        st_nxt = st_r;
        goal = '0;
        // a disabled regulator heads to zero, so start-up ramps too
        if (reg_enable_i) begin
            if (LOW_RANGE) begin
                goal = LRC_LO_BASE_UV
                    + LRC_UVW'(vcode_i) * LRC_LO_STEP_UV;
            end else begin
                goal = LRC_HI_BASE_UV
                    + LRC_UVW'(vcode_i) * LRC_HI_STEP_UV;
            end
        end
        // one rate serves start-up and code changes alike
        step = ramp_slow_i ? LRC_SLOW_STEP_UV : LRC_FAST_STEP_UV;
        if (st_r.cur < goal) begin
            gap = goal - st_r.cur;
            st_nxt.cur = st_r.cur + ((gap > step) ? step : gap);
        end else begin
            gap = st_r.cur - goal;
            st_nxt.cur = st_r.cur - ((gap > step) ? step : gap);
        end
        st_nxt.busy = (st_nxt.cur != goal);
        // the resistor only ever closes with discharge on and output off
        st_nxt.dis = discharge_en_i & ~reg_enable_i;
    end

    // state register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign target_uv_o = st_r.cur;
    assign ramp_busy_o = st_r.busy;
    assign discharge_on_o = st_r.dis;
endmodule

// ### hw/lrc_regs.sv
`timescale 1ns/10ps
module lrc_regs (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [lrc_pkg::LRC_AW-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [lrc_pkg::LRC_DW-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [lrc_pkg::LRC_DW-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [lrc_pkg::LRC_NCH-1:0][lrc_pkg::LRC_VW-1:0] otp_vcode_i,
    input wire logic [lrc_pkg::LRC_NCH-1:0][7:0] otp_ctrl_i,
    input wire logic [lrc_pkg::LRC_NCH-1:0] reg_enable_i,
    input wire logic [lrc_pkg::LRC_NCH-1:0] power_good_i,
    output logic [lrc_pkg::LRC_NCH-1:0][lrc_pkg::LRC_VW-1:0]
        output_voltage_code_o,
    output logic [lrc_pkg::LRC_NCH-1:0] overvoltage_clamp_enable_o,
    output logic [lrc_pkg::LRC_NCH-1:0] auto_low_power_enable_o,
    output logic [lrc_pkg::LRC_NCH-1:0][1:0]
        amplifier_compensation_select_o,
    output logic [lrc_pkg::LRC_NCH-1:0] ramp_rate_select_o,
    output logic [lrc_pkg::LRC_NCH-1:0] discharge_connect_o,
    output logic [lrc_pkg::LRC_NCH-1:0][lrc_pkg::LRC_UVW-1:0]
        regulator_output_target_o,
    output logic [lrc_pkg::LRC_NCH-1:0] ramp_busy_o
);
    import lrc_pkg::*;

    // register bank and bus state in one record
    typedef struct packed {
        logic [LRC_NCH-1:0][LRC_VW-1:0] vcode; // voltage codes
        logic [LRC_NCH-1:0] clamp; // overvoltage clamp enables
        logic [LRC_NCH-1:0] alpm; // auto low-power enables
        logic [LRC_NCH-1:0][1:0] comp; // compensation selects
        logic [LRC_NCH-1:0] ade; // active discharge enables
        logic [LRC_NCH-1:0] ss; // ramp rate selects
        logic [LRC_NCH-1:0] pok; // sampled power-good
        logic loaded; // factory defaults taken
        logic wreq; // waitrequest
        logic [LRC_DW-1:0] rdata; // read data
    } lrc_st_t;

    lrc_st_t st_r;
    lrc_st_t st_nxt;
    logic [7:0] idx; // register index from the byte address
    logic [LRC_NCH-1:0] hit_v; // voltage register selected
    logic [LRC_NCH-1:0] hit_c; // control register selected
    logic [7:0] rd; // read mux result
    logic req; // a transfer is on the bus
    logic ack; // this edge completes the transfer

    // address decode; low two address bits are ignored
    always_comb begin
        idx = avs_address_i[LRC_AW-1:2];
        hit_v = '0;
        hit_c = '0;
        for (int c = 0; c < LRC_NCH; c++) begin
            hit_v[c] = (idx == LRC_VSEL_IDX[c]);
            hit_c[c] = (idx == LRC_CTRL_IDX[c]);
        end
    end

    // read mux; unused and unmapped bits read as zero
    always_comb begin
        rd = 8'h00;
        for (int c = 0; c < LRC_NCH; c++) begin
            if (hit_v[c]) begin
                rd[LRC_VCODE_MSB:0] = st_r.vcode[c];
            end
            if (hit_c[c]) begin
                rd[LRC_CLAMP_BIT] = st_r.clamp[c];
                rd[LRC_ALPM_BIT] = st_r.alpm[c];
                rd[LRC_COMP_MSB:LRC_COMP_LSB] = st_r.comp[c];
                rd[LRC_POK_BIT] = st_r.pok[c];
                rd[LRC_RSVD_BIT] = 1'b0;
                rd[LRC_ADE_BIT] = st_r.ade[c];
                rd[LRC_SS_BIT] = st_r.ss[c];
            end
        end
    end

    // next state: defaults load, bus handshake and register writes
    always_comb begin
        st_nxt = st_r;
        req = avs_read_i | avs_write_i;
        ack = ~st_r.wreq;
        // power-good is synchronous already; one flop sets read timing
        st_nxt.pok = power_good_i;
        // factory defaults are taken at the first edge after reset
        if (!st_r.loaded) begin
            st_nxt.loaded = 1'b1;
            for (int c = 0; c < LRC_NCH; c++) begin
                st_nxt.vcode[c] = otp_vcode_i[c];
                st_nxt.clamp[c] = otp_ctrl_i[c][LRC_CLAMP_BIT];
                st_nxt.alpm[c] = otp_ctrl_i[c][LRC_ALPM_BIT];
                st_nxt.comp[c] =
                    otp_ctrl_i[c][LRC_COMP_MSB:LRC_COMP_LSB];
                st_nxt.ade[c] = otp_ctrl_i[c][LRC_ADE_BIT];
                st_nxt.ss[c] = otp_ctrl_i[c][LRC_SS_BIT];
            end
        end
        if (ack) begin
            // master samples waitrequest low now; raise it again
            st_nxt.wreq = 1'b1;
        end else if (req && st_r.loaded) begin
            // one wait cycle, then answer; unmapped reads return zero
            st_nxt.wreq = 1'b0;
            st_nxt.rdata = avs_read_i ? {24'h000000, rd} : '0;
        end
        // writes land at the completing edge, low byte lane only
        if (ack && avs_write_i && avs_byteenable_i[0]) begin
            for (int c = 0; c < LRC_NCH; c++) begin
                if (hit_v[c]) begin
                    st_nxt.vcode[c] =
                        avs_writedata_i[LRC_VCODE_MSB:0];
                end
                if (hit_c[c]) begin
                    // power-good is status: a write cannot change it
                    st_nxt.clamp[c] =
                        avs_writedata_i[LRC_CLAMP_BIT];
                    st_nxt.alpm[c] =
                        avs_writedata_i[LRC_ALPM_BIT];
                    st_nxt.comp[c] = avs_writedata_i[
                        LRC_COMP_MSB:LRC_COMP_LSB];
                    st_nxt.ade[c] =
                        avs_writedata_i[LRC_ADE_BIT];
                    st_nxt.ss[c] =
                        avs_writedata_i[LRC_SS_BIT];
                end
            end
        end
    end

    // state register; defaults hold until the load edge
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
            st_r.vcode <= {LRC_NCH{LRC_VCODE_RST}};
            st_r.comp <= {LRC_NCH{LRC_COMP_RST}};
            st_r.clamp <= {LRC_NCH{LRC_BIT_RST}};
            st_r.wreq <= LRC_WAIT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bus and control outputs straight from the bank
    assign avs_readdata_o = st_r.rdata;
    assign avs_waitrequest_o = st_r.wreq;
    assign output_voltage_code_o = st_r.vcode;
    assign overvoltage_clamp_enable_o = st_r.clamp;
    assign auto_low_power_enable_o = st_r.alpm;
    assign amplifier_compensation_select_o = st_r.comp;
    assign ramp_rate_select_o = st_r.ss;

    // per-channel ramp and discharge; channel 4 uses the low curve
    genvar g;
    generate
        for (g = 0; g < LRC_NCH; g++) begin : g_ch
            lrc_chan #(
                .LOW_RANGE(g == 0)
            ) u_chan (
                .core_clk_i(core_clk_i),
                .reset_n_i(reset_n_i),
                .vcode_i(st_r.vcode[g]),
                .ramp_slow_i(st_r.ss[g]),
                .discharge_en_i(st_r.ade[g]),
                .reg_enable_i(reg_enable_i[g]),
                .target_uv_o(regulator_output_target_o[g]),
                .ramp_busy_o(ramp_busy_o[g]),
                .discharge_on_o(discharge_connect_o[g])
            );
        end
    endgenerate

    // checks share one clock and the reset
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // a request waits exactly one cycle, then completes for one cycle
    a_bus_ack_timing: assert property (
        (avs_read_i || avs_write_i) && st_r.wreq && st_r.loaded
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest did not answer in one cycle");

    // unmapped reads answer zero
    a_unmapped_zero: assert property (
        $fell(avs_waitrequest_o) && $past(avs_read_i)
        && $past(hit_v == '0) && $past(hit_c == '0)
        |-> avs_readdata_o == '0)
        else $error("unmapped read returned nonzero data");

    // per-channel checks
    generate
        for (g = 0; g < LRC_NCH; g++) begin : g_chk
            logic [LRC_UVW-1:0] prev_t;
            logic [LRC_UVW-1:0] delta;
            logic [LRC_UVW-1:0] lim;
            logic prev_ss; // rate in force when the last move was made
            always_ff @(posedge core_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    prev_t <= '0;
                    prev_ss <= 1'b0;
                end else begin
                    prev_t <= regulator_output_target_o[g];
                    prev_ss <= st_r.ss[g];
                end
            end
            always_comb begin
                delta = (regulator_output_target_o[g] > prev_t)
                    ? regulator_output_target_o[g] - prev_t
                    : prev_t - regulator_output_target_o[g];
                lim = prev_ss
                    ? LRC_SLOW_STEP_UV : LRC_FAST_STEP_UV;
            end

            // written voltage code appears on the next cycle
            a_vcode_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_v[g]
                |=> output_voltage_code_o[g]
                    == $past(avs_writedata_i[LRC_VCODE_MSB:0]))
                else $error("voltage code write not applied");

            // clamp enable follows control bit 7
            a_clamp_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_c[g]
                |=> overvoltage_clamp_enable_o[g]
                    == $past(avs_writedata_i[LRC_CLAMP_BIT]))
                else $error("clamp enable does not follow write");

            // low-power enable follows control bit 6
            a_alpm_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_c[g]
                |=> auto_low_power_enable_o[g]
                    == $past(avs_writedata_i[LRC_ALPM_BIT]))
                else $error("low-power enable does not follow write");

            // compensation follows bits 5:4
            a_comp_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_c[g]
                |=> amplifier_compensation_select_o[g] == $past(
                    avs_writedata_i[LRC_COMP_MSB:LRC_COMP_LSB]))
                else $error("compensation does not follow write");

            // discharge enable follows control bit 1
            a_ade_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_c[g]
                |=> st_r.ade[g]
                    == $past(avs_writedata_i[LRC_ADE_BIT]))
                else $error("discharge enable does not follow write");

            // ramp rate select follows control bit 0
            a_ss_write: assert property (
                !st_r.wreq && avs_write_i && avs_byteenable_i[0]
                && hit_c[g]
                |=> ramp_rate_select_o[g]
                    == $past(avs_writedata_i[LRC_SS_BIT]))
                else $error("ramp rate select does not follow write");

            // control read shows power-good two edges back
            a_pok_read: assert property (
                $fell(avs_waitrequest_o) && $past(avs_read_i)
                && $past(hit_c[g])
                |-> avs_readdata_o[LRC_POK_BIT]
                    == $past(power_good_i[g], 2))
                else $error("power-good read mismatch");

            // voltage reads hold zero in the unused top bits
            a_rsvd_zero: assert property (
                $fell(avs_waitrequest_o) && $past(avs_read_i)
                && $past(hit_v[g])
                |-> avs_readdata_o[7:LRC_VCODE_MSB+1] == 2'h0)
                else $error("unused voltage bits read nonzero");

            // discharge off keeps the resistor open two cycles on
            a_no_discharge: assert property (
                !st_r.ade[g] [*2] |-> !discharge_connect_o[g])
                else $error("resistor connected with discharge off");

            // discharge on and regulator off closes the resistor
            a_discharge_off: assert property (
                st_r.ade[g] && !reg_enable_i[g]
                |=> discharge_connect_o[g])
                else $error("resistor open while regulator off");

            // never faster than the selected ramp rate
            a_ramp_limit: assert property (
                delta <= lim)
                else $error("target moved faster than ramp rate");

            if (g == 0) begin : g_lo
                // settled low-range target matches the curve
                a_lo_curve: assert property (
                    reg_enable_i[g] && !ramp_busy_o[g]
                    && $stable(st_r.vcode[g]) && $stable(reg_enable_i[g])
                    |-> regulator_output_target_o[g] == LRC_LO_BASE_UV
                        + LRC_UVW'(st_r.vcode[g]) * LRC_LO_STEP_UV)
                    else $error("channel 4 target off curve");
            end else begin : g_hi
                // settled high-range target matches the curve
                a_hi_curve: assert property (
                    reg_enable_i[g] && !ramp_busy_o[g]
                    && $stable(st_r.vcode[g]) && $stable(reg_enable_i[g])
                    |-> regulator_output_target_o[g] == LRC_HI_BASE_UV
                        + LRC_UVW'(st_r.vcode[g]) * LRC_HI_STEP_UV)
                    else $error("channel target off curve");
            end
        end
    endgenerate

    // main scenarios
    c_read_done: cover property (
        $fell(avs_waitrequest_o) && $past(avs_read_i));
    c_write_done: cover property (
        !avs_waitrequest_o && avs_write_i);
    c_slow_ramp: cover property (
        st_r.ss[1] && ramp_busy_o[1] [*3]);
    c_discharge: cover property (
        discharge_connect_o[0]);
    c_masked_write: cover property (
        !avs_waitrequest_o && avs_write_i && !avs_byteenable_i[0]);
endmodule

// ### dv/tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the regulator configuration bank
module tb_top;
    import lrc_pkg::*;
    logic core_clk_i; // 10 MHz core clock
    logic reset_n_i; // async reset, active low
    logic [LRC_AW-1:0] addr;
    logic rd, wr;
    logic [LRC_DW-1:0] wdata, rdata;
    logic [3:0] be;
    logic wait_o;
    logic [LRC_NCH-1:0][LRC_VW-1:0] otp_v, vcode_o;
    logic [LRC_NCH-1:0][7:0] otp_c;
    logic [LRC_NCH-1:0] en, pg, clamp_o, alpm_o, slow_o, dis_o, busy_o;
    logic [LRC_NCH-1:0][1:0] comp_o;
    logic [LRC_NCH-1:0][LRC_UVW-1:0] tgt_o;
    int err_total, n_tests;
    logic [31:0] q;
    logic [5:0] v;
    logic [7:0] c;
    logic p;

    lrc_regs i_lrc_regs (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
        .otp_vcode_i(otp_v), .otp_ctrl_i(otp_c), .reg_enable_i(en),
        .power_good_i(pg), .output_voltage_code_o(vcode_o),
        .overvoltage_clamp_enable_o(clamp_o),
        .auto_low_power_enable_o(alpm_o),
        .amplifier_compensation_select_o(comp_o),
        .ramp_rate_select_o(slow_o), .discharge_connect_o(dis_o),
        .regulator_output_target_o(tgt_o), .ramp_busy_o(busy_o));

    // free-running clock, 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // single place where the run ends
    task automatic report_and_stop();
        $display("counts: %0d compared, %0d mismatched", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // compare and count; x or z never matches
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", what, e, g);
        end
    endtask

    // byte addresses are four times the register index
    function automatic logic [9:0] va(input int ch);
        return 10'h160 + 10'(ch * 8);
    endfunction

    // expected target in microvolts: 0.4 V + 12.5 mV or 0.8 V + 50 mV steps
    function automatic logic [21:0] exp_tgt(input int ch, input logic [5:0] k);
        if (ch == 0) begin
            return 22'h061A80 + 22'(k) * 22'h0030D4;
        end
        return 22'h0C3500 + 22'(k) * 22'h00C350;
    endfunction

    // one avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [7:0] d, input logic [3:0] b);
        int n;
        n = 0;
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= {24'(n), d};
        be <= b;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        // an idle edge keeps the driver from touching a strobe twice
        @(posedge core_clk_i);
    endtask

    // wait for a busy level, bounded; n counts the edges spent
    task automatic wait_busy(input int ch, input logic lvl, input int lim,
                             ref int n);
        int k;
        k = 0;
        while (busy_o[ch] !== lvl && k < lim) begin
            @(posedge core_clk_i);
            k++;
            n++;
        end
        if (k >= lim) begin
            err_total++;
            report_and_stop();
        end
    endtask

    // ramp from zero to a code, measure edges until the goal is reached
    task automatic ramp(input int ch, input logic [5:0] k, input logic s);
        int n, e;
        logic [21:0] g;
        g = exp_tgt(ch, k);
        e = (int'(g) + (s ? 499 : 9999)) / (s ? 500 : 10000);
        bus(1'b1, va(ch) + 10'h4, 8'h00, 4'hF);
        en[ch] <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        wait_busy(ch, 1'b0, 500, n);
        bus(1'b1, va(ch), {2'b00, k}, 4'hF);
        bus(1'b1, va(ch) + 10'h4, {7'h00, s}, 4'hF);
        en[ch] <= 1'b1;
        n = 0;
        wait_busy(ch, 1'b1, 5, n);
        wait_busy(ch, 1'b0, 3000, n);
        chk("target", 32'(g), 32'(tgt_o[ch]));
        chk("ramp time", 32'h1, 32'(n >= e - 2 && n <= e + 3));
    endtask

    // main sequence
    initial begin
        void'($urandom(32'hC6D1CD3D));
        reset_n_i = 1'b0;
        {rd, wr, addr, wdata, be, en, pg} = '0;
        for (int i = 0; i < 4; i++) begin
            otp_v[i] = 6'($urandom);
            otp_c[i] = 8'($urandom);
        end
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        @(posedge core_clk_i);
        // factory defaults read back; status and unused bits forced low
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, va(i), 8'h00, 4'hF);
            chk("vsel default", 32'(otp_v[i]), q);
            bus(1'b0, va(i) + 10'h4, 8'h00, 4'hF);
            chk("ctrl default", 32'(otp_c[i] & 8'hF3), q);
        end
        $display("test defaults done");
        // write and read back, extremes first then random
        for (int r = 0; r < 6; r++) begin
            for (int i = 0; i < 4; i++) begin
                v = (r == 0) ? 6'h3F : (r == 1) ? 6'h00 : 6'($urandom);
                c = (r == 0) ? 8'hFB : (r == 1) ? 8'h00 : 8'($urandom);
                c[2] = 1'b0;
                p = (r == 0) ? 1'b1 : 1'($urandom);
                pg[i] <= p;
                en <= 4'($urandom);
                bus(1'b1, va(i), {2'b00, v}, 4'hF);
                bus(1'b1, va(i) + 10'h4, c, 4'hF);
                bus(1'b0, va(i), 8'h00, 4'hF);
                chk("vsel", 32'(v), q);
                bus(1'b0, va(i) + 10'h4, 8'h00, 4'hF);
                chk("ctrl", 32'({c[7:4], p, 1'b0, c[1:0]}), q);
                chk("code out", 32'(v), 32'(vcode_o[i]));
                chk("clamp", 32'(c[7]), 32'(clamp_o[i]));
                chk("low power", 32'(c[6]), 32'(alpm_o[i]));
                chk("comp", 32'(c[5:4]), 32'(comp_o[i]));
                chk("ramp sel", 32'(c[0]), 32'(slow_o[i]));
            end
        end
        $display("test readback done");
        // byte lane 0 off means no write; unmapped index reads zero
        bus(1'b1, va(3), {2'b00, ~v}, 4'hE);
        bus(1'b0, va(3), 8'h00, 4'hF);
        chk("masked write", 32'(v), q);
        bus(1'b1, 10'h180, 8'h5A, 4'hF);
        bus(1'b0, 10'h180, 8'h00, 4'hF);
        chk("unmapped", 32'h0, q);
        $display("test refusals done");
        // discharge switch over all enable and ade combinations
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 4; k++) begin
                bus(1'b1, va(i) + 10'h4, {6'h00, k[1], 1'b0}, 4'hF);
                en[i] <= k[0];
                repeat (3) @(posedge core_clk_i);
                chk("discharge", 32'(k == 2), 32'(dis_o[i]));
            end
        end
        $display("test discharge done");
        // top code 3F at the fast rate on both curves, codes 03 and 00 at the slow rate on the high curve
        ramp(0, 6'h3F, 1'b0);
        ramp(1, 6'h03, 1'b1);
        ramp(3, 6'h3F, 1'b0);
        ramp(2, 6'h00, 1'b1);
        $display("test ramp done");
        report_and_stop();
    end
endmodule
